// ### design/xim_pkg.sv
// Constants, register map and carrier types of the interrupt mux block.
// Assumes one clock domain; CPU side signals are synchronous to pclk.
// Function
// - Hardware trap reacts at once, non-maskably, vectored
// - Each trap sets its own trap flag
// - Trap preempts unless equal or higher trap class in service
// - Trap service blocks interrupts
// - Shared vector structure replicated for vectors 0-3
// - Select register bits 15:8 are enables
// - Select register bits 7:0 are flags
// - Enables mask sources; enabled sources OR together
// - Flags set on event even when disabled
// - Serial receive/transmit events route to vectors 0-2 only
// - Vector 3 carries errors, networks, unlock, PWM
// - Shared vectors at 0100h-010Ch, traps 40h-43h
// - Last shared vector 010Ch, trap 43h, own flags
// - Timer 6 vector 0098h, trap 26h, own flags
// - Converter overrun vector 00A4h, trap 29h
// - Async 0 error vector 00B0h, trap 2Ch
// - Per-source control: request, enable, 16 levels
// - Only strictly higher priority interrupts service
package xim_pkg;
	localparam int XIM_ADDR_W = 8;
	localparam int XIM_NUM_SHARED = 4;
	localparam int XIM_NUM_SRC = 7;
	localparam int XIM_NUM_PERIPH = 14;
	localparam int XIM_NUM_TRAP = 9;
	localparam int XIM_VADDR_W = 24;

	// Register offsets (byte addresses)
	localparam logic [7:0] XIM_OFS_SEL0 = 8'h00;
	localparam logic [7:0] XIM_OFS_TFLAGS = 8'h10;
	localparam logic [7:0] XIM_OFS_CTRL0 = 8'h14;
	localparam logic [7:0] XIM_OFS_IST = 8'h30;
	localparam logic [7:0] XIM_OFS_ICLR = 8'h34;
	localparam logic [7:0] XIM_OFS_IEN = 8'h38;

	// Select register layout
	localparam int XIM_SEL_EN_LSB = 8;
	localparam int XIM_SEL_FLAG_LSB = 0;
	localparam logic [15:0] XIM_SEL_RESET = 16'h0000;

	// Source control register layout
	localparam int XIM_IC_IR = 7;
	localparam int XIM_IC_IE = 6;
	localparam int XIM_IC_LVL_LSB = 2;
	localparam logic [7:0] XIM_IC_RESET = 8'h00;

	// Source indices into the control array
	localparam int XIM_SRC_T6 = 0;
	localparam int XIM_SRC_ADE = 1;
	localparam int XIM_SRC_S0E = 2;
	localparam int XIM_SRC_XP0 = 3;
	localparam logic [6:0][7:0] XIM_SRC_TRAPNUM = {
		8'h43, 8'h42, 8'h41, 8'h40, 8'h2C, 8'h29, 8'h26};

	// Peripheral event indices
	localparam int XIM_EV_CAN1 = 0;
	localparam int XIM_EV_CAN2 = 1;
	localparam int XIM_EV_I2C_RX = 2;
	localparam int XIM_EV_I2C_TX = 3;
	localparam int XIM_EV_I2C_ERR = 4;
	localparam int XIM_EV_SYN2_RX = 5;
	localparam int XIM_EV_SYN2_TX = 6;
	localparam int XIM_EV_SYN2_ERR = 7;
	localparam int XIM_EV_ASY2_RX = 8;
	localparam int XIM_EV_ASY2_TX = 9;
	localparam int XIM_EV_ASY2_TB = 10;
	localparam int XIM_EV_ASY2_ERR = 11;
	localparam int XIM_EV_PLL_OSC = 12;
	localparam int XIM_EV_XPULSE = 13;

	// Trap inputs: 0 NMI, 1 stack over, 2 stack under, 3..8 class B
	localparam int XIM_NUM_TRAP_A = 3;
	localparam logic [8:0][3:0] XIM_TFLAG_POS = {
		4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hD, 4'hE, 4'hF};
	localparam logic [2:0][7:0] XIM_TRAPNUM_A = {8'h06, 8'h04, 8'h02};
	localparam logic [7:0] XIM_TRAPNUM_B = 8'h0A;
	localparam logic [3:0] XIM_TRAP_LEVEL = 4'hF;

	// Event status bits
	localparam int XIM_IST_W = 3;
	localparam int XIM_IST_TRAP = 0;
	localparam int XIM_IST_SHARED = 1;
	localparam int XIM_IST_ACK = 2;

	typedef enum logic [2:0] {
		XIM_TRAP_IDLE = 3'b001,
		XIM_TRAP_SVC_B = 3'b010,
		XIM_TRAP_SVC_A = 3'b100
	} xim_trap_state_type;

	typedef struct packed {
		logic [3:0] cpu_level;
		logic int_ack;
		logic trap_ack;
		logic trap_done;
	} xim_cpu_in_type;

	typedef struct packed {
		logic req;
		logic [XIM_VADDR_W-1:0] addr;
		logic [7:0] trap_num;
		logic [3:0] level;
	} xim_vec_out_type;

	// Routes peripheral events onto one shared vector's eight slots
	function automatic logic [7:0] xim_route(input logic [1:0] v,
			input logic [XIM_NUM_PERIPH-1:0] ev);
		logic [6:0] serial;
		serial = {ev[XIM_EV_ASY2_TB], ev[XIM_EV_ASY2_TX],
			ev[XIM_EV_ASY2_RX], ev[XIM_EV_SYN2_TX],
			ev[XIM_EV_SYN2_RX],
			ev[XIM_EV_I2C_TX], ev[XIM_EV_I2C_RX]};
		case (v)
			2'h0: xim_route = {serial, ev[XIM_EV_CAN1]};
			2'h1: xim_route = {serial, ev[XIM_EV_CAN2]};
			2'h2: xim_route = {serial, ev[XIM_EV_XPULSE]};
			default: xim_route = {1'b0, ev[XIM_EV_XPULSE],
				ev[XIM_EV_PLL_OSC], ev[XIM_EV_ASY2_ERR],
				ev[XIM_EV_SYN2_ERR], ev[XIM_EV_I2C_ERR],
				ev[XIM_EV_CAN2], ev[XIM_EV_CAN1]};
		endcase
	endfunction

	typedef struct packed {
		logic [3:0][15:0] sel;
		logic [6:0][7:0] ctrl;
		logic [15:0] tflags;
		logic [3:0] masked_prev;
		logic [2:0] trap_pend_a;
		logic trap_pend_b;
		xim_trap_state_type trap_state;
		logic [1:0] trap_src;
		logic [2:0] int_src;
		logic [XIM_IST_W-1:0] ist;
		logic [XIM_IST_W-1:0] ien;
		xim_vec_out_type intv;
		xim_vec_out_type trapv;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} xim_state_type;
endpackage

// ### design/xim_top.sv
// Shared vector mux, source control registers and trap sequencer.
// Assumes an APB master on pclk and a CPU that acknowledges vectors.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module xim_top
	import xim_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [XIM_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [XIM_NUM_PERIPH-1:0] periph_event,
	input wire logic timer6_event,
	input wire logic converter_overrun_event,
	input wire logic async0_error_event,
	input wire logic [XIM_NUM_TRAP-1:0] trap_event,
	input wire xim_cpu_in_type cpu_in,
	output xim_vec_out_type int_out,
	output xim_vec_out_type trap_out,
	output logic irq
);
	xim_state_type state_reg;
	xim_state_type state_next;

	logic [3:0][7:0] routed;
	logic [3:0] masked_now;

	// One mux structure per shared vector
	genvar gv;
	generate
		for (gv = 0; gv < XIM_NUM_SHARED; gv++) begin : g_shared
			assign routed[gv] = xim_route(2'(gv), periph_event);
			assign masked_now[gv] = |(state_reg.sel[gv][15:XIM_SEL_EN_LSB]
				& state_reg.sel[gv][7:XIM_SEL_FLAG_LSB]);
		end
	endgenerate

	logic acc;
	logic wr_acc;
	logic [2:0] ci;
	logic [XIM_NUM_SRC-1:0] src_evt;
	logic [3:0] best_lvl;
	logic best_hit;
	logic [2:0] best_idx;
	logic [3:0] lvl;
	logic [1:0] a_idx;
	logic a_hit;
	logic [7:0] tnum;

	always_comb begin
		state_next = state_reg;
		acc = 1'b0;
		wr_acc = 1'b0;
		ci = 3'h0;
		src_evt = '0;
		best_lvl = 4'h0;
		best_hit = 1'b0;
		best_idx = 3'h0;
		lvl = 4'h0;
		a_idx = 2'h0;
		a_hit = 1'b0;
		tnum = 8'h00;

		// APB: access phase answered after one wait cycle
		acc = psel & penable & state_reg.pready;
		wr_acc = acc & pwrite;
		state_next.pready = psel & penable & ~state_reg.pready;
		state_next.pslverr = 1'b0;
		state_next.prdata = 32'h0000_0000;

		// Software writes first, hardware sets below take precedence
		if (paddr[1:0] != 2'b00) begin
			state_next.pslverr = psel & penable & ~state_reg.pready;
		end else if (paddr < XIM_OFS_TFLAGS) begin
			state_next.prdata = {16'h0000, state_reg.sel[paddr[3:2]]};
			if (wr_acc) begin
				state_next.sel[paddr[3:2]] = pwdata[15:0];
			end
		end else if (paddr == XIM_OFS_TFLAGS) begin
			state_next.prdata = {16'h0000, state_reg.tflags};
			if (wr_acc) begin
				state_next.tflags = state_reg.tflags
					& ~pwdata[15:0];
			end
		end else if (paddr >= XIM_OFS_CTRL0 && paddr < XIM_OFS_IST) begin
			ci = 3'((paddr - XIM_OFS_CTRL0) >> 2);
			state_next.prdata = {24'h000000, state_reg.ctrl[ci]};
			if (wr_acc) begin
				state_next.ctrl[ci] = pwdata[7:0];
			end
		end else if (paddr == XIM_OFS_IST) begin
			state_next.prdata = {29'h0, state_reg.ist};
		end else if (paddr == XIM_OFS_ICLR) begin
			if (wr_acc) begin
				state_next.ist = state_reg.ist & ~pwdata[XIM_IST_W-1:0];
			end
		end else if (paddr == XIM_OFS_IEN) begin
			state_next.prdata = {29'h0, state_reg.ien};
			if (wr_acc) begin
				state_next.ien = pwdata[XIM_IST_W-1:0];
			end
		end else begin
			state_next.pslverr = psel & penable & ~state_reg.pready;
		end

		// Flags set regardless of enables
		for (int v = 0; v < XIM_NUM_SHARED; v++) begin
			state_next.sel[v][7:0] = state_next.sel[v][7:0]
				| routed[v];
		end

		// A vector going from no to any enabled-and-flagged source raises the shared request
		state_next.masked_prev = masked_now;
		src_evt[XIM_SRC_T6] = timer6_event;
		src_evt[XIM_SRC_ADE] = converter_overrun_event;
		src_evt[XIM_SRC_S0E] = async0_error_event;
		for (int v = 0; v < XIM_NUM_SHARED; v++) begin
			src_evt[XIM_SRC_XP0 + v] = masked_now[v]
				& ~state_reg.masked_prev[v];
		end

		// Interrupt ack clears the presented request
		if (cpu_in.int_ack && state_reg.intv.req) begin
			state_next.ctrl[state_reg.int_src][XIM_IC_IR] = 1'b0;
		end
		for (int i = 0; i < XIM_NUM_SRC; i++) begin
			if (src_evt[i]) begin
				state_next.ctrl[i][XIM_IC_IR] = 1'b1;
			end
		end

		// Trap flags and pending traps
		for (int t = 0; t < XIM_NUM_TRAP; t++) begin
			if (trap_event[t]) begin
				state_next.tflags[XIM_TFLAG_POS[t]] = 1'b1;
			end
		end
		if (cpu_in.trap_ack && state_reg.trapv.req) begin
			if (state_reg.trap_src == 2'h3) begin
				state_next.trap_pend_b = 1'b0;
				state_next.trap_state = XIM_TRAP_SVC_B;
			end else begin
				state_next.trap_pend_a[state_reg.trap_src] = 1'b0;
				state_next.trap_state = XIM_TRAP_SVC_A;
			end
		end else if (cpu_in.trap_done) begin
			state_next.trap_state = XIM_TRAP_IDLE;
		end
		state_next.trap_pend_a = state_next.trap_pend_a
			| trap_event[XIM_NUM_TRAP_A-1:0];
		state_next.trap_pend_b = state_next.trap_pend_b
			| (|trap_event[XIM_NUM_TRAP-1:XIM_NUM_TRAP_A]);

		// Trap request: class A over class B, waits on equal or higher
		for (int a = XIM_NUM_TRAP_A - 1; a >= 0; a--) begin
			if (state_next.trap_pend_a[a]) begin
				a_hit = 1'b1;
				a_idx = 2'(a);
			end
		end
		state_next.trapv = '0;
		state_next.trap_src = state_reg.trap_src;
		case (state_next.trap_state)
			XIM_TRAP_IDLE: begin
				if (a_hit) begin
					state_next.trapv.req = 1'b1;
					state_next.trap_src = a_idx;
					tnum = XIM_TRAPNUM_A[a_idx];
				end else if (state_next.trap_pend_b) begin
					state_next.trapv.req = 1'b1;
					state_next.trap_src = 2'h3;
					tnum = XIM_TRAPNUM_B;
				end
			end
			XIM_TRAP_SVC_B: begin
				if (a_hit) begin
					state_next.trapv.req = 1'b1;
					state_next.trap_src = a_idx;
					tnum = XIM_TRAPNUM_A[a_idx];
				end
			end
			XIM_TRAP_SVC_A: begin
				tnum = 8'h00;
			end
			default: begin
				state_next.trap_state = XIM_TRAP_IDLE;
			end
		endcase
		state_next.trapv.trap_num = tnum;
		state_next.trapv.addr = XIM_VADDR_W'({tnum, 2'b00});
		state_next.trapv.level = XIM_TRAP_LEVEL;
		if (!state_next.trapv.req) begin
			state_next.trapv.addr = '0;
			state_next.trapv.trap_num = 8'h00;
		end

		// Standard request: highest enabled level, ties to lower index
		for (int i = XIM_NUM_SRC - 1; i >= 0; i--) begin
			lvl = state_next.ctrl[i][XIM_IC_LVL_LSB +: 4];
			if (state_next.ctrl[i][XIM_IC_IR]
					&& state_next.ctrl[i][XIM_IC_IE]
					&& (!best_hit || lvl >= best_lvl)) begin
				best_hit = 1'b1;
				best_lvl = lvl;
				best_idx = 3'(i);
			end
		end
		state_next.intv = '0;
		state_next.int_src = state_reg.int_src;
		if (best_hit && best_lvl > cpu_in.cpu_level
				&& state_next.trap_state == XIM_TRAP_IDLE
				&& !state_next.trapv.req) begin
			state_next.intv.req = 1'b1;
			state_next.intv.trap_num = XIM_SRC_TRAPNUM[best_idx];
			state_next.intv.addr = XIM_VADDR_W'(
				{XIM_SRC_TRAPNUM[best_idx], 2'b00});
			state_next.intv.level = best_lvl;
			state_next.int_src = best_idx;
		end
		if (cpu_in.int_ack && state_reg.intv.req) begin
			state_next.intv = '0;
		end

		// Event status, hardware sets beat the clear register
		if (|trap_event) begin
			state_next.ist[XIM_IST_TRAP] = 1'b1;
		end
		if (|src_evt[XIM_NUM_SRC-1:XIM_SRC_XP0]) begin
			state_next.ist[XIM_IST_SHARED] = 1'b1;
		end
		if (cpu_in.int_ack && state_reg.intv.req) begin
			state_next.ist[XIM_IST_ACK] = 1'b1;
		end
		state_next.irq = |(state_next.ist & state_next.ien);

		if (!ce) begin
			state_next = state_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg.sel <= {XIM_NUM_SHARED{XIM_SEL_RESET}};
			state_reg.ctrl <= {XIM_NUM_SRC{XIM_IC_RESET}};
			state_reg.tflags <= 16'h0000;
			state_reg.masked_prev <= 4'h0;
			state_reg.trap_pend_a <= 3'h0;
			state_reg.trap_pend_b <= 1'b0;
			state_reg.trap_state <= XIM_TRAP_IDLE;
			state_reg.trap_src <= 2'h0;
			state_reg.int_src <= 3'h0;
			state_reg.ist <= '0;
			state_reg.ien <= '0;
			state_reg.intv <= '0;
			state_reg.trapv <= '0;
			state_reg.irq <= 1'b0;
			state_reg.pready <= 1'b0;
			state_reg.pslverr <= 1'b0;
			state_reg.prdata <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign int_out = state_reg.intv;
	assign trap_out = state_reg.trapv;
	assign irq = state_reg.irq;
endmodule

// ### test/xim_cpu.sv
// CPU model: takes offered vectors, ends trap service a few cycles later.
// Assumes the mux top on the same pclk.
`timescale 1ns/1ps
module xim_cpu
	import xim_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] lvl,
	input wire xim_vec_out_type iv,
	input wire xim_vec_out_type tv,
	output xim_cpu_in_type cpu
);
	logic h;
	logic [2:0] w;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu <= '0;
			h <= 1'h0;
			w <= '0;
		end else begin
			h <= cpu.int_ack;
			cpu.int_ack <= iv.req && !cpu.int_ack && !h;
			cpu.trap_ack <= tv.req && !cpu.trap_ack;
			cpu.trap_done <= w == 3'h1;
			w <= cpu.trap_ack ? 3'h5 : w - 3'(w != 3'h0);
			cpu.cpu_level <= lvl;
		end
	end
endmodule

// ### test/xim_top_properties.sv
// Port assertions for the interrupt mux top.
// Assumes trap_ack and trap_done are one-cycle CPU pulses.
`timescale 1ns/1ps
module xim_chk
	import xim_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [XIM_NUM_TRAP-1:0] trap_event,
	input wire xim_cpu_in_type cpu_in,
	input wire xim_vec_out_type int_out,
	input wire xim_vec_out_type trap_out
);
	logic svc;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			svc <= 1'h0;
		else if (cpu_in.trap_ack || cpu_in.trap_done)
			svc <= cpu_in.trap_ack;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_iadr;
		int_out.req |-> int_out.addr == {int_out.trap_num, 2'h0};
	endproperty
	a_iadr: assert property (p_iadr) else $error("int address");
	property p_tadr;
		trap_out.req |-> trap_out.addr == {trap_out.trap_num, 2'h0};
	endproperty
	a_tadr: assert property (p_tadr) else $error("trap address");
	property p_tlvl;
		trap_out.req |-> trap_out.level == 4'hF;
	endproperty
	a_tlvl: assert property (p_tlvl) else $error("trap level");
	property p_nmi;
		ce && trap_event[0] && !svc && !cpu_in.trap_ack
			|=> trap_out.req && trap_out.trap_num == 8'h02;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi missed");
	property p_blk;
		svc |-> !int_out.req;
	endproperty
	a_blk: assert property (p_blk) else $error("int in trap");
	property p_lvl;
		int_out.req |-> int_out.level > $past(cpu_in.cpu_level);
	endproperty
	a_lvl: assert property (p_lvl) else $error("int level");
	property p_num;
		int_out.req |-> int_out.trap_num inside {8'h26, 8'h29, 8'h2C,
			[8'h40:8'h43]};
	endproperty
	a_num: assert property (p_num) else $error("int number");
	property p_ack;
		int_out.req && cpu_in.int_ack |=> !int_out.req ||
			int_out.trap_num != $past(int_out.trap_num);
	endproperty
	a_ack: assert property (p_ack) else $error("ack kept");
	c_int: cover property (int_out.req && cpu_in.int_ack);
	c_trap: cover property (trap_out.req && cpu_in.trap_ack);
	c_done: cover property (svc && cpu_in.trap_done);
endmodule
bind xim_top xim_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
	.trap_event(trap_event), .cpu_in(cpu_in), .int_out(int_out),
	.trap_out(trap_out));

// ### test/tb_top.sv
// Self-checking bench: APB, shared vectors, traps and irq of the mux.
// Assumes the CPU model answers every vector it is offered.
`timescale 1ns/1ps
module tb_top
	import xim_pkg::*;
;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, pready, pslverr, irq;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic [13:0] pev = '0;
	logic [2:0] sev = '0;
	logic [8:0] tev = '0;
	logic [3:0] lvl = '0;
	logic [33:0] nb, bq[$];
	logic [31:0] vq[$], tq[$];
	logic [31:0] xm[14] = '{32'h01000001, 32'h02000100, 32'h00020202,
		32'h00040404, 32'h04000000, 32'h00080808, 32'h00101010,
		32'h08000000, 32'h00202020, 32'h00404040, 32'h00808080,
		32'h10000000, 32'h20000000, 32'h40010000};
	int miscompares = 0, compares = 0, seed = 66828;
	xim_cpu_in_type cpu;
	xim_vec_out_type iv, tv;
	initial forever #5 pclk = ~pclk;
	xim_top dut (.pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.periph_event(pev), .timer6_event(sev[0]),
		.converter_overrun_event(sev[1]), .async0_error_event(sev[2]),
		.trap_event(tev), .cpu_in(cpu), .int_out(iv), .trap_out(tv),
		.irq(irq));
	xim_cpu u_cpu (.pclk(pclk), .presetn(presetn), .lvl(lvl), .iv(iv),
		.tv(tv), .cpu(cpu));
	task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic close_out();
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
			logic [32:0] e);
		bq.push_back({w, e});
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'h1, a, d, '0);
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e);
		apb(1'h0, a, '0, {1'h0, e});
	endtask
	task automatic pulse(logic [13:0] p, logic [2:0] s, logic [8:0] t);
		pev <= p;
		sev <= s;
		tev <= t;
		@(posedge pclk);
		pev <= '0;
		sev <= '0;
		tev <= '0;
	endtask
	task automatic drain();
		int n;
		n = 0;
		while (vq.size() + tq.size() > 0 && n++ < 300)
			@(posedge pclk);
		cmp("vector wait", 32'h0, 32'(vq.size() + tq.size()));
		repeat (8) @(posedge pclk);
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'h1) begin
			nb = bq.size() ? bq.pop_front() : '1;
			cmp("pslverr", 32'(nb[32]), 32'(pslverr));
			if (!nb[33])
				cmp("prdata", nb[31:0], prdata);
		end
		if (iv.req && cpu.int_ack)
			cmp("int", vq.size() ? vq.pop_front() : '1,
				{iv.trap_num, iv.addr});
		if (tv.req && cpu.trap_ack)
			cmp("trap", tq.size() ? tq.pop_front() : '1,
				{tv.trap_num, tv.addr});
	end
	initial begin
		logic [3:0] lv[3];
		logic [7:0] t;
		static int tp[9] = '{15, 14, 13, 7, 6, 3, 2, 1, 0};
		static logic [7:0] tn[3] = '{8'h26, 8'h29, 8'h2C};
		static logic [13:0] sp[4] = '{14'h5, 14'h2, 14'h2000, 14'h1000};
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		for (int a = 0; a < 4; a++)
			rd(8'(4 * a), 32'h0);
		apb(1'h0, 8'hFC, '0, {1'h1, 32'h0});
		apb(1'h1, 8'h06, '0, {1'h1, 32'h0});
		for (int i = 0; i < 7; i++) begin
			t = {2'h1, 4'($random(seed)) | 4'h1, 2'h0};
			if (i < 3)
				lv[i] = t[5:2];
			wr(8'(8'h14 + 4 * i), 32'(t));
			rd(8'(8'h14 + 4 * i), 32'(t));
		end
		// Enables clear: flags only, no vector
		for (int e = 0; e < 14; e++) begin
			pulse(14'(1 << e), '0, '0);
			for (int v = 0; v < 4; v++) begin
				rd(8'(4 * v), {24'h0, xm[e][8 * v +: 8]});
				wr(8'(4 * v), 32'h0);
			end
		end
		for (int v = 0; v < 4; v++) begin
			t = 8'(8'h40 + v);
			vq.push_back({t, 14'h0, t, 2'h0});
			wr(8'(4 * v), 32'h0000FF00);
			pulse(sp[v], '0, '0);
			drain();
			wr(8'(4 * v), 32'h0);
		end
		lvl <= 4'hF;
		@(posedge pclk);
		pulse('0, 3'h7, '0);
		repeat (20) @(posedge pclk);
		for (int l = 15; l > 0; l--)
			for (int i = 0; i < 3; i++)
				if (lv[i] == l)
					vq.push_back({tn[i], 14'h0, tn[i], 2'h0});
		lvl <= 4'h0;
		drain();
		for (int k = 0; k < 9; k++) begin
			t = k < 3 ? 8'(2 + 2 * k) : 8'h0A;
			tq.push_back({t, 14'h0, t, 2'h0});
			if (k == 3)
				vq.push_back({8'h26, 24'h98});
			pulse('0, 3'(k == 3), 9'(1 << k));
			drain();
			rd(8'h10, 32'(1 << tp[k]));
			wr(8'h10, 32'hFFFF);
		end
		tq.push_back({8'h02, 24'h8});
		tq.push_back({8'h0A, 24'h28});
		pulse('0, '0, 9'h9);
		drain();
		rd(8'h10, 32'h8080);
		rd(8'h30, 32'h7);
		cmp("irq", 32'h0, 32'(irq));
		wr(8'h38, 32'h2);
		repeat (2) @(posedge pclk);
		cmp("irq", 32'h1, 32'(irq));
		wr(8'h34, 32'h7);
		rd(8'h30, 32'h0);
		cmp("irq", 32'h0, 32'(irq));
		rd(8'h38, 32'h2);
		close_out();
	end
	initial begin
		#300000 miscompares++;
		close_out();
	end
endmodule
